/* File: fcs_consts.vh */
// Constants for the flash command sequencer
`ifndef FCS_CONSTS_VH
`define FCS_CONSTS_VH
`define FCS_ADDR_CLKDIV   4'h0
`define FCS_ADDR_SEC      4'h1
`define FCS_ADDR_INDEX    4'h2
`define FCS_ADDR_CONFIG   4'h3
`define FCS_ADDR_STATUS   4'h4
`define FCS_ADDR_PPROT    4'h5
`define FCS_ADDR_DPROT    4'h6
`define FCS_ADDR_PARAM    4'h7
`define FCS_ADDR_VERSION  4'h8
`define FCS_ST_CCF        7
`define FCS_ST_ACCESS_ERROR_FLAG     5
`define FCS_ST_PVIOL      4
`define FCS_DIVLD_BIT     7
`define FCS_PP_OPEN       7
`define FCS_PP_HDIS       5
`define FCS_PP_LDIS       2
`define FCS_DP_OPEN       7
`define FCS_VERSION_RST   16'h0001
`define FCS_CMD_EVALL     8'h01
`define FCS_CMD_EVBLK     8'h02
`define FCS_CMD_EVSEC     8'h03
`define FCS_CMD_RDONCE    8'h04
`define FCS_CMD_PROG      8'h06
`define FCS_CMD_PGONCE    8'h07
`define FCS_CMD_ERALL     8'h08
`define FCS_CMD_ERBLK     8'h09
`define FCS_CMD_ERSEC     8'h0A
`define FCS_CMD_UNSEC     8'h0B
`define FCS_CMD_BDKEY     8'h0C
`define FCS_CMD_UMRG      8'h0D
`define FCS_CMD_FMRG      8'h0E
`define FCS_CMD_DEVSEC    8'h10
`define FCS_CMD_DPROG     8'h11
`define FCS_CMD_DERSEC    8'h12
`define FCS_ONCE_WORDS    32
`define FCS_OP_CYCLES     8'h10
`endif

/* File: fcs_tick_div.v */
// Flash time base divider: one-cycle enable pulse
`timescale 1ns/1ps
module fcs_tick_div (
    input  wire       ref_clk_i,
    input  wire       srst_i,
    input  wire [6:0] div_i,
    output reg        tick_o
);
    reg [6:0] cnt_reg;
    always @(posedge ref_clk_i) begin
        if (srst_i) begin
            cnt_reg <= 7'h00;
            tick_o  <= 1'b0;
        end else if (cnt_reg >= div_i) begin
            // Period is divider value plus one bus clocks
            cnt_reg <= 7'h00;
            tick_o  <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 7'h01;
            tick_o  <= 1'b0;
        end
    end
endmodule

/* File: fcs_sequencer.v */
// Flash command sequencer with register port and array model
//
// Implementation choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "fcs_consts.vh"
module fcs_sequencer (
    input  wire        ref_clk_i,
    input  wire        srst_i,
    input  wire        special_mode_input_i,
    input  wire [3:0]  addr_i,
    input  wire [15:0] wdata_i,
    input  wire        wr_i,
    input  wire        rd_i,
    output reg  [15:0] rdata_o,
    output reg         busy_o,
    output reg         secured_o
);
    ////////////////////////////////////////////////////////////////
    // Registers
    localparam ST_IDLE = 2'b00;
    localparam ST_RUN  = 2'b01;
    localparam ST_DONE = 2'b10;

    reg [1:0]  state_reg;
    reg [6:0]  divider_value_reg;
    reg        divider_loaded_reg;
    reg        sec_unlocked_reg;
    reg [2:0]  param_index_reg;
    reg [7:0]  config_reg;
    reg [7:0]  program_array_protection_reg;
    reg [7:0]  data_array_protection_reg;
    reg        command_complete_flag_reg;
    reg        access_error_flag_reg;
    reg        protection_violation_flag_reg;
    reg [15:0] param_reg [0:5];
    reg [15:0] once_mem [0:`FCS_ONCE_WORDS-1];
    reg        once_done_reg;
    reg        prog_erased_reg;
    reg        data_erased_reg;
    reg [15:0] version_reg;
    reg [7:0]  run_cnt_reg;
    reg [7:0]  cmd_reg;
    reg        fail_reg;
    integer    i;
    integer    j;

    wire       tick;
    wire       mode_special = special_mode_input_i;
    wire       secured      = ~sec_unlocked_reg;
    wire [7:0] new_cmd      = param_reg[0][15:8];
    wire [4:0] once_base    = {param_reg[1][1:0], 3'b000};
    // Block and program section checks look at the program array only; the data section check looks at the data array
    wire       verify_fail  = (cmd_reg == `FCS_CMD_EVALL) ?
                              ~(prog_erased_reg & data_erased_reg) :
                              (cmd_reg == `FCS_CMD_DEVSEC) ?
                              ~data_erased_reg : ~prog_erased_reg;

    // Divider runs free, so the first tick of a run may come early
    fcs_tick_div u_tick (
        .ref_clk_i (ref_clk_i),
        .srst_i    (srst_i),
        .div_i     (divider_value_reg),
        .tick_o    (tick)
    );

    ////////////////////////////////////////////////////////////////
    // Command legality by mode and security
    reg cmd_valid;
    reg cmd_allowed;
    reg cmd_pe;
    always @* begin
        cmd_valid   = 1'b1;
        cmd_allowed = 1'b0;
        cmd_pe      = 1'b0;
        case (new_cmd)
            `FCS_CMD_EVALL, `FCS_CMD_EVBLK:
                cmd_allowed = 1'b1;
            `FCS_CMD_EVSEC, `FCS_CMD_RDONCE, `FCS_CMD_UMRG:
                cmd_allowed = ~(mode_special & secured);
            `FCS_CMD_PROG, `FCS_CMD_PGONCE: begin
                cmd_allowed = ~(mode_special & secured);
                cmd_pe      = 1'b1;
            end
            `FCS_CMD_ERALL, `FCS_CMD_UNSEC: begin
                cmd_allowed = mode_special;
                cmd_pe      = 1'b1;
            end
            `FCS_CMD_ERBLK, `FCS_CMD_ERSEC,
            `FCS_CMD_DPROG, `FCS_CMD_DERSEC: begin
                cmd_allowed = ~(mode_special & secured);
                cmd_pe      = 1'b1;
            end
            `FCS_CMD_DEVSEC:
                cmd_allowed = ~(mode_special & secured);
            `FCS_CMD_BDKEY:
                cmd_allowed = ~mode_special;
            `FCS_CMD_FMRG:
                cmd_allowed = mode_special & ~secured;
            default:
                cmd_valid = 1'b0;
        endcase
    end

    // Launch is taken only while idle; busy writes other than status flag clears are dropped
    wire status_wr = wr_i & (addr_i == `FCS_ADDR_STATUS);
    wire launch    = status_wr & wdata_i[`FCS_ST_CCF] &
                     command_complete_flag_reg &
                     ~access_error_flag_reg &
                     ~protection_violation_flag_reg;
    wire reject    = ~cmd_valid | ~cmd_allowed |
                     (cmd_pe & ~divider_loaded_reg);
    wire erall_ok  = program_array_protection_reg[`FCS_PP_OPEN] &
                     program_array_protection_reg[`FCS_PP_HDIS] &
                     program_array_protection_reg[`FCS_PP_LDIS] &
                     data_array_protection_reg[`FCS_DP_OPEN];
    wire idle_wr   = wr_i & command_complete_flag_reg;
    // Launch outcome, settled in the cycle of the status write
    wire erall_bad = (new_cmd == `FCS_CMD_ERALL) & ~erall_ok;
    wire once_dup  = (new_cmd == `FCS_CMD_PGONCE) & once_done_reg;
    wire acc_set   = launch & (reject | once_dup);
    wire pv_set    = launch & ~reject & erall_bad;
    wire accept    = launch & ~reject & ~erall_bad & ~once_dup;

    ////////////////////////////////////////////////////////////////
    // Status error flags
    always @(posedge ref_clk_i) begin
        if (srst_i) begin
            access_error_flag_reg         <= 1'b0;
            protection_violation_flag_reg <= 1'b0;
        end else begin
            // Write-one-to-clear; a set from a launch wins the cycle
            // A refused launch never touches the run state
            if (acc_set)
                access_error_flag_reg <= 1'b1;
            else if (status_wr & wdata_i[`FCS_ST_ACCESS_ERROR_FLAG])
                access_error_flag_reg <= 1'b0;
            if (pv_set)
                protection_violation_flag_reg <= 1'b1;
            else if (status_wr & wdata_i[`FCS_ST_PVIOL])
                protection_violation_flag_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Register writes, sequencing and execution
    always @(posedge ref_clk_i) begin
        if (srst_i) begin
            state_reg                     <= ST_IDLE;
            divider_value_reg             <= 7'h00;
            divider_loaded_reg            <= 1'b0;
            sec_unlocked_reg              <= 1'b0;
            param_index_reg               <= 3'h0;
            config_reg                    <= 8'h00;
            program_array_protection_reg  <= 8'h00;
            data_array_protection_reg     <= 8'h00;
            command_complete_flag_reg     <= 1'b1;
            once_done_reg                 <= 1'b0;
            prog_erased_reg               <= 1'b1;
            data_erased_reg               <= 1'b1;
            version_reg                   <= `FCS_VERSION_RST;
            run_cnt_reg                   <= 8'h00;
            cmd_reg                       <= 8'h00;
            fail_reg                      <= 1'b0;
            for (i = 0; i < 6; i = i + 1) begin
                param_reg[i] <= 16'h0000;
            end
        end else begin
            if (idle_wr) begin
                case (addr_i)
                    `FCS_ADDR_CLKDIV: begin
                        divider_value_reg  <= wdata_i[6:0];
                        divider_loaded_reg <= 1'b1;
                    end
                    `FCS_ADDR_INDEX:
                        param_index_reg <= wdata_i[2:0];
                    `FCS_ADDR_CONFIG:
                        config_reg <= wdata_i[7:0];
                    `FCS_ADDR_PPROT:
                        program_array_protection_reg <= wdata_i[7:0];
                    // Normal unsecured mode keeps data protection locked
                    `FCS_ADDR_DPROT:
                        if (mode_special | secured)
                            data_array_protection_reg <= wdata_i[7:0];
                    `FCS_ADDR_PARAM:
                        if (param_index_reg < 3'h6)
                            param_reg[param_index_reg] <= wdata_i;
                    default: begin
                    end
                endcase
            end
            case (state_reg)
                ST_IDLE: begin
                    if (accept) begin
                        command_complete_flag_reg <= 1'b0;
                        cmd_reg     <= new_cmd;
                        run_cnt_reg <= `FCS_OP_CYCLES;
                        fail_reg    <= 1'b0;
                        state_reg   <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    // Array timing is paced by the flash time base
                    if (tick) begin
                        if (run_cnt_reg == 8'h00)
                            state_reg <= ST_DONE;
                        else
                            run_cnt_reg <= run_cnt_reg - 8'h01;
                    end
                end
                ST_DONE: begin
                    case (cmd_reg)
                        `FCS_CMD_EVALL, `FCS_CMD_EVBLK,
                        `FCS_CMD_EVSEC, `FCS_CMD_DEVSEC: begin
                            fail_reg <= verify_fail;
                            param_reg[1] <= {15'h0000, verify_fail};
                        end
                        `FCS_CMD_RDONCE:
                            for (i = 0; i < 4; i = i + 1) begin
                                param_reg[i+2] <=
                                    once_mem[once_base + i[4:0]];
                            end
                        `FCS_CMD_PGONCE: begin
                            for (i = 0; i < 4; i = i + 1) begin
                                once_mem[once_base + i[4:0]] <=
                                    param_reg[i+2];
                            end
                            once_done_reg <= 1'b1;
                        end
                        `FCS_CMD_PROG:
                            prog_erased_reg <= 1'b0;
                        `FCS_CMD_DPROG:
                            data_erased_reg <= 1'b0;
                        `FCS_CMD_ERALL, `FCS_CMD_UNSEC: begin
                            // Erasure never re-arms the one-time field
                            prog_erased_reg <= 1'b1;
                            data_erased_reg <= 1'b1;
                            if (cmd_reg == `FCS_CMD_UNSEC)
                                sec_unlocked_reg <= 1'b1;
                        end
                        `FCS_CMD_BDKEY:
                            sec_unlocked_reg <= 1'b1;
                        default: begin
                        end
                    endcase
                    command_complete_flag_reg <= 1'b1;
                    state_reg <= ST_IDLE;
                end
                default:
                    state_reg <= ST_IDLE;
            endcase
        end
    end

    // One-time field storage is kept out of reset on purpose
    initial begin
        for (j = 0; j < `FCS_ONCE_WORDS; j = j + 1) begin
            once_mem[j] = 16'hFFFF;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Read port, data one cycle after the strobe
    always @(posedge ref_clk_i) begin
        if (srst_i) begin
            rdata_o   <= 16'h0000;
            busy_o    <= 1'b0;
            secured_o <= 1'b1;
        end else begin
            busy_o    <= ~command_complete_flag_reg;
            secured_o <= secured;
            // Unmapped addresses and idle cycles read back zero
            rdata_o   <= 16'h0000;
            if (rd_i) begin
                case (addr_i)
                    `FCS_ADDR_CLKDIV:
                        rdata_o <= {8'h00, divider_loaded_reg, 
                                    divider_value_reg};
                    `FCS_ADDR_SEC:
                        rdata_o <= {15'h0000, secured};
                    `FCS_ADDR_INDEX:
                        rdata_o <= {13'h0000, param_index_reg};
                    `FCS_ADDR_CONFIG:
                        rdata_o <= {8'h00, config_reg};
                    `FCS_ADDR_STATUS:
                        rdata_o <= {8'h00, command_complete_flag_reg,
                                    1'b0, access_error_flag_reg,
                                    protection_violation_flag_reg,
                                    3'b000, fail_reg};
                    `FCS_ADDR_PPROT:
                        rdata_o <= {8'h00, program_array_protection_reg};
                    `FCS_ADDR_DPROT:
                        rdata_o <= {8'h00, data_array_protection_reg};
                    `FCS_ADDR_PARAM:
                        if (param_index_reg < 3'h6)
                            rdata_o <= param_reg[param_index_reg];
                    `FCS_ADDR_VERSION:
                        rdata_o <= {12'h000, version_reg[3:0]};
                    default:
                        rdata_o <= 16'h0000;
                endcase
            end
        end
    end
endmodule

/* File: fcs_cmd_rules.sv */
// Command admission model: which codes run in each mode and security state
`timescale 1ns/1ps
module fcs_cmd_rules (
    input  wire [7:0] cmd_i,
    input  wire       special_i,
    input  wire       secured_i,
    output reg        allowed_o
);
    always @* begin
        case (cmd_i)
            8'h01, 8'h02: allowed_o = 1'b1;
            8'h03, 8'h04, 8'h06, 8'h07, 8'h0D,
            8'h09, 8'h0A, 8'h10, 8'h11, 8'h12:
                allowed_o = !(special_i && secured_i);
            8'h08, 8'h0B: allowed_o = special_i;
            8'h0C: allowed_o = !special_i;
            8'h0E: allowed_o = special_i && !secured_i;
            // Unknown codes never reach the array
            default: allowed_o = 1'b0;
        endcase
    end
endmodule

/* File: fcs_seq_asserts.sv */
// Port-level temporal checks for the flash command sequencer
`timescale 1ns/1ps
module fcs_seq_asserts (
    input wire        ref_clk_i,
    input wire        srst_i,
    input wire        special_mode_input_i,
    input wire [3:0]  addr_i,
    input wire [15:0] wdata_i,
    input wire        wr_i,
    input wire        rd_i,
    input wire [15:0] rdata_o,
    input wire        busy_o,
    input wire        secured_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);
    idle_after_reset_a: assert property (
        $fell(srst_i) |-> !busy_o && secured_o)
        else $error("sequencer not idle after reset");
    rdata_quiet_a: assert property (
        !$past(rd_i) |-> rdata_o == 16'h0000)
        else $error("read data outside read answer");
    version_read_a: assert property (
        $past(rd_i) && $past(addr_i) == 4'h8 |-> rdata_o == 16'h0001)
        else $error("version word wrong");
    launch_cause_a: assert property (
        $rose(busy_o) |-> $past(wr_i, 2) && $past(addr_i, 2) == 4'h4
                          && $past(wdata_i[7], 2))
        else $error("busy without launch write");
    busy_min_a: assert property (
        $rose(busy_o) |-> busy_o [*8])
        else $error("command ended too soon");
    busy_bound_a: assert property (
        $rose(busy_o) |-> ##[1:300] !busy_o)
        else $error("command never completed");
    flag_read_a: assert property (
        $past(rd_i) && $past(addr_i) == 4'h4 |-> rdata_o[7] == !busy_o)
        else $error("complete flag disagrees with busy");
    secure_fall_a: assert property (
        $fell(secured_o) |-> $past(busy_o) || busy_o)
        else $error("security released without command");
    secure_hold_a: assert property (
        1'b1 |-> !$rose(secured_o))
        else $error("security set again");
endmodule

/* File: flash_command_sequencer_bench.sv */
// Self-checking bench for the flash command sequencer
`timescale 1ns/1ps
`define CHK(g, e) begin \
    cmp_count = cmp_count + 1; \
    if ((g) !== (e)) begin \
        bad_count = bad_count + 1; \
        $display("wrong value at %0t: %h vs %h", $time, g, e); \
    end \
end
module flash_command_sequencer_bench;
    localparam [119:0] CODES = 120'h01020304060708090A0D0E10111205;
    reg         clk, srst, mode, wr, rd;
    reg  [3:0]  addr;
    reg  [15:0] wd, got, msk, exs;
    wire [15:0] rdata;
    wire        busy, sec, allowed;
    reg  [7:0]  cur_cmd;
    reg  [15:0] dw [2:5];
    reg  [15:0] once_q [$];
    reg         dl, once_done, prot_open, exp_sec, exp_run, acc, pv;
    reg         vfail, perased, derased;
    integer     bad_count, cmp_count, seed, i, m, k, n;
    fcs_sequencer dut (.ref_clk_i(clk), .srst_i(srst),
        .special_mode_input_i(mode), .addr_i(addr), .wdata_i(wd),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .busy_o(busy),
        .secured_o(sec));
    fcs_cmd_rules rules (.cmd_i(cur_cmd), .special_i(mode),
        .secured_i(exp_sec), .allowed_o(allowed));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task end_of_test;
        begin
            if (bad_count == 0 && cmp_count > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask
    task wr_reg(input [3:0] a, input [15:0] d);
        begin
            @(posedge clk);
            addr <= a;
            wd   <= d;
            wr   <= 1'b1;
            @(posedge clk);
            wr   <= 1'b0;
        end
    endtask
    task rd_reg(input [3:0] a);
        begin
            @(posedge clk);
            addr <= a;
            rd   <= 1'b1;
            @(posedge clk);
            rd   <= 1'b0;
            #1 got = rdata;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Load all six words, launch, and compare against the admission model
    task run_cmd(input [7:0] c);
        begin
            cur_cmd = c;
            // Small word count keeps section verify inside the array
            dw[2] = ($random(seed) & 16'h000F) | 16'h0001;
            for (k = 3; k < 6; k = k + 1)
                dw[k] = $random(seed);
            wr_reg(4'h2, 16'h0000);
            wr_reg(4'h7, {c, 8'h00});
            wr_reg(4'h2, 16'h0001);
            wr_reg(4'h7, 16'h0000);
            for (k = 2; k < 6; k = k + 1) begin
                wr_reg(4'h2, k[15:0]);
                wr_reg(4'h7, dw[k]);
            end
            wr_reg(4'h2, 16'h0000);
            exp_run = allowed && !(c == 8'h06 && !dl)
                && !(c == 8'h08 && !prot_open) && !(c == 8'h07 && once_done);
            pv  = c == 8'h08 && allowed && !prot_open;
            acc = !exp_run && !pv;
            // Verify outcome follows which arrays were written since erasure
            if (exp_run) begin
                if (c == 8'h01)
                    vfail = !(perased && derased);
                else if (c == 8'h10)
                    vfail = !derased;
                else if (c == 8'h02 || c == 8'h03)
                    vfail = !perased;
                else
                    vfail = 1'b0;
                if (c == 8'h06)
                    perased = 1'b0;
                if (c == 8'h11)
                    derased = 1'b0;
                if (c == 8'h08 || c == 8'h0B)
                    {perased, derased} = 2'b11;
            end
            wr_reg(4'h4, 16'h0080);
            repeat (2) @(posedge clk);
            #1 `CHK(busy, exp_run)
            if (busy === 1'b1)
                wr_reg(4'h7, 16'hFF00);
            n = 0;
            while (busy !== 1'b0 && n < 1000) begin
                @(posedge clk);
                n = n + 1;
            end
            if (n >= 1000) begin
                bad_count = bad_count + 1;
                end_of_test;
            end
            msk = 16'h00B1;
            exs = {8'h00, 1'b1, 1'b0, acc, pv, 3'h0, vfail};
            rd_reg(4'h4);
            `CHK(got & msk, exs)
            rd_reg(4'h7);
            `CHK(got, {c, 8'h00})
            if (exp_run && c == 8'h07) begin
                once_done = 1'b1;
                for (k = 2; k < 6; k = k + 1)
                    once_q.push_back(dw[k]);
            end
            // Errors cleared before the next launch
            wr_reg(4'h4, 16'h0030);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 49;
        bad_count = 0;
        cmp_count = 0;
        {srst, mode, wr, rd, addr, wd, cur_cmd} = {1'b1, 31'h0};
        {dl, once_done, prot_open, exp_sec} = 4'h1;
        {vfail, perased, derased} = 3'h3;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        rd_reg(4'h4);
        `CHK(got, 16'h0080)
        rd_reg(4'h0);
        `CHK(got, 16'h0000)
        rd_reg(4'h8);
        `CHK(got, 16'h0001)
        `CHK(sec, 1'b1)
        run_cmd(8'h06);
        wr_reg(4'h0, 16'h0001);
        dl = 1'b1;
        rd_reg(4'h0);
        `CHK(got, 16'h0081)
        wr_reg(4'h2, 16'h0006);
        wr_reg(4'h7, $random(seed));
        rd_reg(4'h7);
        `CHK(got, 16'h0000)
        wr_reg(4'h5, 16'h0000);
        wr_reg(4'h6, 16'h0000);
        for (m = 0; m < 2; m = m + 1) begin
            mode <= m[0];
            for (i = 0; i < 15; i = i + 1)
                run_cmd(CODES[8*i +: 8]);
        end
        mode <= 1'b0;
        run_cmd(8'h04);
        for (k = 2; k < 6; k = k + 1) begin
            wr_reg(4'h2, k[15:0]);
            rd_reg(4'h7);
            `CHK(got, once_q[k-2])
        end
        run_cmd(8'h07);
        mode <= 1'b1;
        wr_reg(4'h5, 16'h00A4);
        wr_reg(4'h6, 16'h0080);
        prot_open = 1'b1;
        run_cmd(8'h08);
        run_cmd(8'h0C);
        run_cmd(8'h0B);
        exp_sec = 1'b0;
        `CHK(sec, 1'b0)
        run_cmd(8'h0E);
        run_cmd(8'h01);
        run_cmd(8'h07);
        end_of_test;
    end
endmodule
bind fcs_sequencer fcs_seq_asserts chk (.ref_clk_i(ref_clk_i),
    .srst_i(srst_i), .special_mode_input_i(special_mode_input_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .busy_o(busy_o), .secured_o(secured_o));
